// *** sadc_consts.vh ***
// register map, field positions, channel codes and timing counts for the converter control
`ifndef SADC_CONSTS_VH
`define SADC_CONSTS_VH
`define SADC_OFS_CTRL0 12'h000
`define SADC_OFS_CTRL1 12'h004
`define SADC_OFS_RESH 12'h008
`define SADC_OFS_RESL 12'h00C
`define SADC_OFS_FLAGS 12'h010
`define SADC_OFS_SYS 12'h014
`define SADC_C0_ON 0
`define SADC_C0_GO 1
`define SADC_C0_CHS_LO 2
`define SADC_C1_PREF_LO 0
`define SADC_C1_NREF 2
`define SADC_C1_CS_LO 4
`define SADC_C1_FMT 7
`define SADC_FL_FLAG 0
`define SADC_FL_IE 1
`define SADC_SY_GIE 0
`define SADC_SY_PERIPHERAL_IRQ_ENABLE 1
`define SADC_CHS_TEMP 5'h1D
`define SADC_CHS_DAC 5'h1E
`define SADC_CHS_FVR 5'h1F
`define SADC_RES_BITS 10
`define SADC_TAD_HALF 5'h17
`define SADC_RC_DIV 8'h0C
`endif

// *** sadc_divider.v ***
// programmable system clock divider producing one-cycle tick enables
`timescale 1ns/10ps
`default_nettype none
module sadc_divider #(
    parameter W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire [W-1:0] div,
    output reg tick
);
    reg [W-1:0] cnt_reg;
    // count to div-1 then pulse; restart whenever run drops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= {W{1'b0}};
            tick <= 1'b0;
        end else if (!run) begin
            cnt_reg <= {W{1'b0}};
            tick <= 1'b0;
        end else if (cnt_reg >= div - {{(W-1){1'b0}}, 1'b1}) begin
            cnt_reg <= {W{1'b0}};
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** sadc_sync.v ***
// two flip-flop level synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sadc_sync (
    input wire pclk,
    input wire presetn,
    input wire d,
    output reg q
);
    reg meta_reg;
    // first stage read only by the second
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// *** sadc_ctrl.v ***
// successive-approximation converter control with APB register slave
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sadc_consts.vh"
// Summary of operation
// - resolve each sample to 10 bits by successive approximation into result pair
// - one sample-and-hold; channel select routes a single input to it
// - fourteen sources: inputs 13-8, 4-0, temperature, DAC, fixed reference
// - positive reference: external pin, supply, fixed 2.048V or fixed 4.096V
// - negative reference bit picks external pin or ground
// - clock select maps codes to divide by 2..64 or the RC oscillator
// - one bit per conversion clock period, 11.5 periods per conversion
// - divided clocks follow system clock; RC clock is independent
// - conversions run during sleep only with the RC clock selected
// - completion flag set after every conversion regardless of enable
// - hardware never clears the completion flag; software writes zero
// - interrupt request only when flag and interrupt enable are both set
// - converter interrupt request wakes the device from sleep
// - after wake next instruction runs; service only if both enables set
// - format bit picks left or right justification of the result
// - converter powered only while enabled; go starts; not both in one write
// - on completion clear go, set flag, load both result registers
// - aborted conversion stores partial result, unresolved bits copy last bit
// - five-bit channel code; 11101 temp, 11110 DAC, 11111 fixed; reserved none
module sadc_ctrl #(
    parameter RC_DIV = 8'h0C
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire rc_osc_pin,
    input wire sleep_pin,
    input wire comp_out_pin,
    output reg [9:0] dac_trial,
    output reg sample_hold,
    output reg [4:0] mux_sel,
    output reg mux_valid,
    output reg [1:0] pos_ref_sel,
    output reg neg_ref_sel,
    output reg analog_power,
    output reg irq_req,
    output reg wake_req,
    output reg isr_vector
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    reg conv_enable_reg;
    reg go_reg;
    reg [4:0] chan_reg;
    reg [1:0] pref_reg;
    reg nref_reg;
    reg [2:0] cs_reg;
    reg fmt_reg;
    reg flag_reg;
    reg ie_reg;
    reg gie_reg;
    reg peripheral_irq_enable_reg;
    reg [9:0] result_reg;
    reg [9:0] sar_reg;
    reg [9:0] sar_trial_next;
    reg [4:0] half_reg;
    reg [1:0] state_reg;
    reg rc_prev_reg;
    wire rc_s;
    wire comp_s;
    wire sleep_s;
    wire div_tick;
    reg [7:0] div_sel;
    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT = 2'b01;
    localparam ST_CONV = 2'b10;
    sadc_sync u_rc (.pclk(pclk), .presetn(presetn), .d(rc_osc_pin), .q(rc_s));
    // comparator only answers our own registered trial code on pclk; two sync
    // stages would make the answer late for a /2 tad, so it is read directly
    assign comp_s = comp_out_pin;
    sadc_sync u_slp (.pclk(pclk), .presetn(presetn), .d(sleep_pin), .q(sleep_s));

    ////////////////////////////////////////////////////////////////////////
    // conversion clock selection
    wire use_rc = (cs_reg[1:0] == 2'b11);
    // divide ratios; a /2 tick gives half-periods at pclk/1 so one tad is 2 cycles
    always @* begin
        case (cs_reg)
            3'b000: div_sel = 8'h01;
            3'b100: div_sel = 8'h02;
            3'b001: div_sel = 8'h04;
            3'b101: div_sel = 8'h08;
            3'b010: div_sel = 8'h10;
            3'b110: div_sel = 8'h20;
            default: div_sel = 8'h01;
        endcase
    end
    // divided rates track pclk; rc ticks on each rc edge, pclk-independent
    sadc_divider #(.W(8)) u_div (
        .pclk(pclk), .presetn(presetn), .run(state_reg != ST_IDLE && !use_rc),
        .div(div_sel), .tick(div_tick)
    );
    wire rc_edge = rc_s ^ rc_prev_reg;
    wire half_tick = use_rc ? rc_edge : div_tick;
    // sleep halts conversions unless rc clock selected
    wire sleep_abort = sleep_s && !use_rc;

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    wire wr = psel && penable && pwrite && pready;
    wire rd_setup = psel && !penable && !pwrite;
    wire hit_c0 = paddr == `SADC_OFS_CTRL0;
    wire hit_c1 = paddr == `SADC_OFS_CTRL1;
    wire hit_fl = paddr == `SADC_OFS_FLAGS;
    wire hit_sy = paddr == `SADC_OFS_SYS;
    wire hit_any = hit_c0 || hit_c1 || hit_fl || hit_sy ||
        paddr == `SADC_OFS_RESH || paddr == `SADC_OFS_RESL;
    wire go_wr = wr && hit_c0 && pwdata[`SADC_C0_GO];
    // go only honoured if converter already on before this write
    wire start = go_wr && conv_enable_reg && state_reg == ST_IDLE;
    wire sw_abort = wr && hit_c0 && !pwdata[`SADC_C0_GO] && state_reg != ST_IDLE;
    // the 23rd half tick closes the trailing half tad
    wire finish = state_reg == ST_CONV && half_tick && half_reg == `SADC_TAD_HALF - 5'h01;
    wire abort = (sw_abort || sleep_abort || !conv_enable_reg) && state_reg != ST_IDLE;
    // partial result: unresolved bits copy last resolved bit
    reg [9:0] partial;
    integer i;
    always @* begin
        partial = sar_reg;
        for (i = 8; i >= 0; i = i - 1) begin
            if ({27'h0, half_reg} < 2 * (9 - i) + 4)
                partial[i] = partial[i + 1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb response, no wait state; ready and read data come from flops loaded in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit_any;
            if (rd_setup) begin
                prdata <= 32'h00000000;
                if (hit_c0)
                    prdata[6:0] <= {chan_reg, go_reg, conv_enable_reg};
                if (hit_c1)
                    prdata[7:0] <= {fmt_reg, cs_reg, 1'b0, nref_reg, pref_reg};
                if (paddr == `SADC_OFS_RESH)
                    prdata[7:0] <= fmt_reg ? {6'h00, result_reg[9:8]} : result_reg[9:2];
                if (paddr == `SADC_OFS_RESL)
                    prdata[7:0] <= fmt_reg ? result_reg[7:0] : {result_reg[1:0], 6'h00};
                if (hit_fl)
                    prdata[1:0] <= {ie_reg, flag_reg};
                if (hit_sy)
                    prdata[1:0] <= {peripheral_irq_enable_reg, gie_reg};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_enable_reg <= 1'b0;
            chan_reg <= 5'h00;
            pref_reg <= 2'h0;
            nref_reg <= 1'b0;
            cs_reg <= 3'h0;
            fmt_reg <= 1'b0;
            ie_reg <= 1'b0;
            gie_reg <= 1'b0;
            peripheral_irq_enable_reg <= 1'b0;
        end else if (wr) begin
            if (hit_c0) begin
                conv_enable_reg <= pwdata[`SADC_C0_ON];
                chan_reg <= pwdata[6:2];
            end
            if (hit_c1) begin
                pref_reg <= pwdata[1:0];
                nref_reg <= pwdata[`SADC_C1_NREF];
                cs_reg <= pwdata[6:4];
                fmt_reg <= pwdata[`SADC_C1_FMT];
            end
            if (hit_fl)
                ie_reg <= pwdata[`SADC_FL_IE];
            if (hit_sy) begin
                gie_reg <= pwdata[`SADC_SY_GIE];
                peripheral_irq_enable_reg <= pwdata[`SADC_SY_PERIPHERAL_IRQ_ENABLE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // completion flag: set wins over a software clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            flag_reg <= 1'b0;
        else if (finish)
            flag_reg <= 1'b1;
        else if (wr && hit_fl)
            flag_reg <= pwdata[`SADC_FL_FLAG] & flag_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: wait one tad after go (two with the rc clock), then 10 bits, then a half tad
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            go_reg <= 1'b0;
            half_reg <= 5'h00;
            sar_reg <= 10'h000;
            result_reg <= 10'h000;
            rc_prev_reg <= 1'b0;
        end else begin
            rc_prev_reg <= rc_s;
            case (state_reg)
                ST_IDLE: begin
                    half_reg <= 5'h00;
                    if (start) begin
                        go_reg <= 1'b1;
                        sar_reg <= 10'h200;
                        state_reg <= use_rc ? ST_WAIT : ST_CONV;
                    end
                end
                ST_WAIT: begin
                    // rc clock waits an extra instruction slot for the sleep entry
                    if (abort) begin
                        go_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else if (half_tick) begin
                        half_reg <= half_reg + 5'h01;
                        if (half_reg == 5'h01) begin
                            half_reg <= 5'h00;
                            state_reg <= ST_CONV;
                        end
                    end
                end
                ST_CONV: begin
                    if (abort) begin
                        go_reg <= 1'b0;
                        result_reg <= partial;
                        state_reg <= ST_IDLE;
                    end else if (finish) begin
                        go_reg <= 1'b0;
                        result_reg <= sar_reg;
                        state_reg <= ST_IDLE;
                    end else if (half_tick) begin
                        half_reg <= half_reg + 5'h01;
                        // decide one bit at the end of each tad after the first
                        if (half_reg >= 5'h03 && half_reg[0] && half_reg <= 5'h15) begin
                            sar_reg <= sar_trial_next;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
    // bit under trial for the present tad
    wire [4:0] bit_off = half_reg - 5'h03;
    wire [3:0] bit_idx = 4'h9 - bit_off[4:1];
    always @* begin
        sar_trial_next = sar_reg;
        if (!comp_s)
            sar_trial_next[bit_idx] = 1'b0;
        if (bit_idx != 4'h0)
            sar_trial_next[bit_idx - 4'h1] = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // analog side and interrupt outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_trial <= 10'h000;
            sample_hold <= 1'b0;
            mux_sel <= 5'h00;
            mux_valid <= 1'b0;
            pos_ref_sel <= 2'h0;
            neg_ref_sel <= 1'b0;
            analog_power <= 1'b0;
            irq_req <= 1'b0;
            wake_req <= 1'b0;
            isr_vector <= 1'b0;
        end else begin
            dac_trial <= sar_reg;
            // drop hold with the abort so it never outlives the power
            sample_hold <= state_reg == ST_CONV && !abort;
            mux_sel <= chan_reg;
            // reserved codes connect nothing
            mux_valid <= chan_reg <= 5'h04 || (chan_reg >= 5'h08 && chan_reg <= 5'h0D) ||
                chan_reg >= `SADC_CHS_TEMP;
            pos_ref_sel <= pref_reg;
            neg_ref_sel <= nref_reg;
            analog_power <= conv_enable_reg && !(sleep_abort && state_reg == ST_IDLE);
            irq_req <= flag_reg && ie_reg;
            wake_req <= sleep_s && flag_reg && ie_reg;
            isr_vector <= flag_reg && ie_reg && gie_reg && peripheral_irq_enable_reg;
        end
    end
endmodule
`default_nettype wire

// *** sadc_analog.sv ***
// stand-in for the input mux, sample-and-hold and comparator
`timescale 1ns/10ps
`default_nettype none
module sadc_analog (
    input wire logic pclk,
    input wire logic [9:0] dac_trial,
    input wire logic sample_hold,
    input wire logic [4:0] mux_sel,
    input wire logic mux_valid,
    input wire logic analog_power,
    output logic comp_out_pin
);
    logic [9:0] level;
    logic wander_reg;
    ////////////////////////////////////////////////////////////////////////////////
    // each real source has its own level; reserved codes see ground
    // inputs are pure analog here: no digital buffer loads the level
    assign level = mux_valid ? {mux_sel, 5'h15} : 10'h000;
    // output only means something while holding; otherwise it wanders
    assign comp_out_pin = (analog_power && sample_hold) ? (level >= dac_trial) : wander_reg;
    // toggles every cycle so a stale compare cannot pass by luck
    initial wander_reg = 1'b0;
    always @(posedge pclk) begin
        wander_reg <= ~wander_reg;
    end
endmodule
`default_nettype wire

// *** sadc_ctrl_asserts.sv ***
// port-level checks for the converter control
`timescale 1ns/10ps
`default_nettype none
module sadc_ctrl_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sample_hold,
    input wire logic [4:0] mux_sel,
    input wire logic mux_valid,
    input wire logic analog_power,
    input wire logic irq_req,
    input wire logic wake_req,
    input wire logic isr_vector
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] since_clr_reg;
    ////////////////////////////////////////////////////////////////////////////////
    // cycles since software last wrote the flag register, saturating
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_clr_reg <= 3'h7;
        end else if (psel && penable && pready && pwrite && paddr == 12'h010) begin
            since_clr_reg <= 3'h0;
        end else if (since_clr_reg != 3'h7) begin
            since_clr_reg <= since_clr_reg + 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no answer one cycle after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error response without ready");
    AST_PRDATA_HOLD: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data moved without a read setup");
    // flag only drops after a software write, never by itself
    AST_FLAG_STICKY: assert property ($fell(irq_req) |-> since_clr_reg <= 3'h2)
        else $error("request dropped with no flag write");
    AST_WAKE_NEEDS_IRQ: assert property (wake_req |-> irq_req)
        else $error("wake without interrupt request");
    AST_ISR_NEEDS_IRQ: assert property (isr_vector |-> irq_req)
        else $error("service vector without interrupt request");
    AST_HOLD_NEEDS_POWER: assert property (sample_hold |-> analog_power)
        else $error("converting while powered down");
    AST_MUX_CODES: assert property (mux_valid |-> mux_sel <= 5'h04 || mux_sel >= 5'h1D ||
        (mux_sel >= 5'h08 && mux_sel <= 5'h0D))
        else $error("reserved channel code marked as a source");
    cover property ($fell(sample_hold));
    cover property (wake_req);
    cover property (isr_vector);
    cover property (pslverr);
endmodule
bind sadc_ctrl sadc_ctrl_asserts i_sadc_ctrl_asserts (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_hold(sample_hold), .mux_sel(mux_sel),
    .mux_valid(mux_valid), .analog_power(analog_power), .irq_req(irq_req),
    .wake_req(wake_req), .isr_vector(isr_vector));
`default_nettype wire

// *** sadc_ctrl_bench.sv ***
// self-checking bench for the converter control
`timescale 1ns/10ps
`default_nettype none
module sadc_ctrl_bench;
    logic pclk, presetn, psel, penable, pwrite, rc_osc_pin, sleep_pin, comp_out_pin, err;
    logic pready, pslverr, sample_hold, mux_valid, neg_ref_sel, analog_power;
    logic irq_req, wake_req, isr_vector;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] dac_trial;
    logic [4:0] mux_sel;
    logic [4:0] chans [15];
    logic [1:0] pos_ref_sel;
    logic [2:0] rc_cnt;
    int errors, checks;
    sadc_ctrl i_sadc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rc_osc_pin(rc_osc_pin), .sleep_pin(sleep_pin),
        .comp_out_pin(comp_out_pin), .dac_trial(dac_trial), .sample_hold(sample_hold),
        .mux_sel(mux_sel), .mux_valid(mux_valid), .pos_ref_sel(pos_ref_sel),
        .neg_ref_sel(neg_ref_sel), .analog_power(analog_power), .irq_req(irq_req),
        .wake_req(wake_req), .isr_vector(isr_vector));
    sadc_analog i_sadc_analog (.pclk(pclk), .dac_trial(dac_trial), .sample_hold(sample_hold),
        .mux_sel(mux_sel), .mux_valid(mux_valid), .analog_power(analog_power),
        .comp_out_pin(comp_out_pin));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // slow free-running rc source, toggled from pclk every 8 cycles by a counter
    always @(posedge pclk) begin
        rc_cnt <= rc_cnt + 3'h1;
        if (rc_cnt == 3'h4) rc_osc_pin <= ~rc_osc_pin;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one apb transfer; holds everything until ready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) begin
            errors++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // waits for the hold window to open and close, counting its length
    task automatic wait_done(output int hi);
        int k;
        hi = 0;
        for (k = 0; k < 3000; k++) begin
            @(posedge pclk);
            if (sample_hold === 1'b1) hi++;
            else if (hi > 0) break;
        end
        if (k == 3000) begin
            errors++;
            end_of_test();
        end
    endtask
    function automatic logic [9:0] fill(input logic [9:0] v, input int k);
        logic [9:0] r;
        r = v;
        for (int b = 9 - k; b >= 0; b--) r[b] = v[10 - k];
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_map();
        for (int a = 0; a < 24; a += 4) begin
            apb(1'b0, 12'(a), 32'h0);
            chk(rd, 32'h0);
            chk(32'(err), 32'(a == 20 ? 0 : 0));
        end
        apb(1'b1, 12'h018, 32'hFF);
        chk(32'(err), 32'h1);
        apb(1'b1, 12'h000, 32'h2);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_convert(input logic [4:0] ch, input logic [2:0] cs, input logic fmt,
        input logic [1:0] pref, input logic nref);
        int hi, nn;
        logic [9:0] e;
        nn = 2 << {cs[1:0], cs[2]};
        e = (ch == 5'h05) ? 10'h000 : {ch, 5'h15};
        apb(1'b1, 12'h004, {24'h0, fmt, cs, 1'b0, nref, pref});
        apb(1'b1, 12'h000, {25'h0, ch, 2'b01});
        repeat (8) @(posedge pclk);
        chk(32'({mux_sel, pos_ref_sel, neg_ref_sel, analog_power}), 32'({ch, pref, nref, 1'b1}));
        apb(1'b1, 12'h000, {25'h0, ch, 2'b11});
        wait_done(hi);
        if (cs[1:0] != 2'b11) chk(32'(hi >= 23 * nn / 2 && hi <= 23 * nn / 2 + 1), 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, {25'h0, ch, 2'b01});
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, fmt ? 32'(e[9:8]) : 32'(e[9:2]));
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, fmt ? 32'(e[7:0]) : 32'({e[1:0], 6'h00}));
        apb(1'b1, 12'h010, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h1);
        chk(32'(irq_req), 32'h0);
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_abort();
        int hi;
        logic hit;
        logic [9:0] f;
        hit = 1'b0;
        apb(1'b1, 12'h004, {24'h0, 8'hE0});
        apb(1'b1, 12'h000, {25'h0, 5'h0D, 2'b11});
        repeat (300) @(posedge pclk);
        apb(1'b1, 12'h000, {25'h0, 5'h0D, 2'b01});
        repeat (8) @(posedge pclk);
        apb(1'b0, 12'h00C, 32'h0);
        for (int k = 1; k < 10; k++) begin
            f = fill(10'h1B5, k);
            if (rd[7:0] === f[7:0]) hit = 1'b1;
        end
        chk(32'(hit), 32'h1);
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h000, {25'h0, 5'h0D, 2'b11});
        repeat (50) @(posedge pclk);
        sleep_pin <= 1'b1;
        wait_done(hi);
        chk(32'(hi < 200), 32'h1);
        sleep_pin <= 1'b0;
    endtask
    task automatic t_irq();
        int hi;
        apb(1'b1, 12'h010, 32'h2);
        apb(1'b1, 12'h014, 32'h3);
        apb(1'b1, 12'h004, {24'h0, 8'h30});
        apb(1'b1, 12'h000, {25'h0, 5'h1F, 2'b01});
        sleep_pin <= 1'b1;
        apb(1'b1, 12'h000, {25'h0, 5'h1F, 2'b11});
        wait_done(hi);
        repeat (6) @(posedge pclk);
        chk(32'({irq_req, wake_req, isr_vector}), 32'h7);
        sleep_pin <= 1'b0;
        apb(1'b1, 12'h014, 32'h1);
        repeat (6) @(posedge pclk);
        chk(32'({irq_req, wake_req, isr_vector}), 32'h4);
        apb(1'b1, 12'h010, 32'h2);
        repeat (4) @(posedge pclk);
        chk(32'({irq_req, wake_req, isr_vector}), 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        chans = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h08, 5'h09, 5'h0A, 5'h0B,
            5'h0C, 5'h0D, 5'h1D, 5'h1E, 5'h1F};
        errors = 0;
        checks = 0;
        {presetn, psel, penable, pwrite, rc_osc_pin, sleep_pin} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        rc_cnt = 3'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_map();
        for (int i = 0; i < 15; i++) t_convert(chans[i], 3'(i), i[0], 2'(i), i[1]);
        t_abort();
        t_irq();
        end_of_test();
    end
endmodule
`default_nettype wire
